// *** verilog/eil_defines.vh ***
// Constants for the external interrupt latch block
`ifndef EIL_DEFINES_VH
`define EIL_DEFINES_VH
`define EIL_ADDR_STATUS_CONTROL 12'h000
`define EIL_ADDR_INT_STATUS     12'h004
`define EIL_ADDR_INT_MASK       12'h008
`define EIL_ADDR_VECTOR         12'h00C
`define EIL_BIT_MODE            0
`define EIL_BIT_MASK            1
`define EIL_BIT_ACK             2
`define EIL_BIT_FLAG            3
`define EIL_BIT_EVENT           0
`define EIL_VEC_ADDR_HI         16'hFFFA
`define EIL_VEC_ADDR_LO         16'hFFFB
`define EIL_VECTOR_RESET        16'h0000
`endif

// *** verilog/eil_external_interrupt_latch.v ***
// External interrupt latch with APB registers
`timescale 1ns/1ps
`include "eil_defines.vh"

// Two-flop synchroniser; only the second stage leaves this module
// Costs two cycles of latency on every pin change
module eil_sync_cell #(
    parameter [0:0] RESET_LEVEL = 1'b1
) (
    input  wire clock,
    input  wire reset,
    input  wire din,
    output wire dout
);
    reg stage1_r;
    reg stage2_r;

    // Reset to the idle level so release gives no false edge
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            stage1_r <= RESET_LEVEL;
            stage2_r <= RESET_LEVEL;
        end else begin
            stage1_r <= din;
            stage2_r <= stage1_r;
        end
    end

    assign dout = stage2_r;
endmodule // eil_sync_cell

// Edge and level trigger with the latch and its clear rules
// Pulses shorter than one clock period may be missed; level mode
// keeps the request up for as long as the pin stays low
module eil_trigger_latch (
    input  wire clock,
    input  wire reset,
    input  wire pin_sync,
    input  wire level_mode,
    input  wire ack,
    output wire latch,
    output wire latch_next,
    output wire set_event
);
    reg  prev_r;
    reg  latch_r;
    reg  ack_pend_r;
    wire fall;
    wire level_hold;
    wire ack_seen;
    wire clear;
    wire latch_nxt;
    wire ack_pend_nxt;

    // Previous synchronised level, idle high like the pin
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= pin_sync;
        end
    end

    assign fall       = prev_r & ~pin_sync;
    assign level_hold = level_mode & ~pin_sync;
    assign ack_seen   = ack | ack_pend_r;

    // Level mode clears only once acknowledge and pin high both seen
    assign clear = level_mode ? (ack_seen & pin_sync) : ack;

    // Set wins over clear so a fresh edge is never lost
    assign latch_nxt = fall | level_hold | (latch_r & ~clear);

    // Acknowledge taken while the pin is still low waits for its rise
    assign ack_pend_nxt = latch_nxt & ~fall & level_mode & ack_seen;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            latch_r    <= 1'b0;
            ack_pend_r <= 1'b0;
        end else begin
            latch_r    <= latch_nxt;
            ack_pend_r <= ack_pend_nxt;
        end
    end

    assign latch      = latch_r;
    assign latch_next = latch_nxt;
    assign set_event  = fall | (latch_nxt & ~latch_r);
endmodule // eil_trigger_latch

// Sticky event bit, write one to clear; a set in the same cycle wins
// Used for the interrupt status bit
module eil_sticky_flag (
    input  wire clock,
    input  wire reset,
    input  wire raise,
    input  wire clear,
    output wire flag,
    output wire flag_next
);
    reg  flag_r;
    wire flag_nxt;

    assign flag_nxt = raise | (flag_r & ~clear);

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag      = flag_r;
    assign flag_next = flag_nxt;
endmodule // eil_sticky_flag

// Top: register interface, latch, status and CPU side outputs
// Writes commit at the edge that completes the transfer, so a
// stalled master never sees a half-applied write
module eil_external_interrupt_latch #(
    parameter [15:0] VECTOR_DEFAULT = `EIL_VECTOR_RESET
) (
    input  wire        clock,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        irq_pin_n,
    input  wire        vector_fetch,
    input  wire        vector_byte_sel,
    input  wire        break_state,
    input  wire        break_clear_enable,
    input  wire        wait_mode,
    input  wire        stop_mode,
    output reg         cpu_request,
    output reg         wakeup,
    output reg  [7:0]  vector_byte,
    output reg         pin_level,
    output reg         irq
);
    // Word offsets; every register is one aligned 32-bit word
    localparam [11:0] ADDR_CTRL   = `EIL_ADDR_STATUS_CONTROL;
    localparam [11:0] ADDR_STATUS = `EIL_ADDR_INT_STATUS;
    localparam [11:0] ADDR_MASK   = `EIL_ADDR_INT_MASK;
    localparam [11:0] ADDR_VECTOR = `EIL_ADDR_VECTOR;

    // Register state
    reg        mode_r;
    reg        mask_r;
    reg        int_mask_r;
    reg [15:0] vector_r;
    reg [31:0] read_word;

    // Bus decode
    wire       access_first;
    wire       access_done;
    wire       wr_done;
    wire       rd_first;
    wire       hit_ctrl;
    wire       hit_status;
    wire       hit_mask;
    wire       hit_vector;
    wire       addr_ok;
    wire       wr_ctrl;
    wire       wr_status;
    wire       wr_mask;
    wire       wr_vector;

    // Latch side
    wire       pin_sync;
    wire       sw_ack_write;
    wire       ack_allowed;
    wire       sw_ack;
    wire       any_ack;
    wire       latch;
    wire       latch_nxt;
    wire       set_event;
    wire       int_status;
    wire       int_status_nxt;
    wire       status_clear;
    wire       request_nxt;
    wire       wake_nxt;

    // First access edge raises pready, completion edge commits
    assign access_first = psel & penable & ~pready;
    assign access_done  = psel & penable & pready;
    assign wr_done      = access_done & pwrite;
    assign rd_first     = access_first & ~pwrite;

    // Address decode
    assign hit_ctrl   = (paddr == ADDR_CTRL);
    assign hit_status = (paddr == ADDR_STATUS);
    assign hit_mask   = (paddr == ADDR_MASK);
    assign hit_vector = (paddr == ADDR_VECTOR);
    assign addr_ok    = hit_ctrl | hit_status | hit_mask | hit_vector;

    // Write strobes, one per register word
    assign wr_ctrl   = wr_done & hit_ctrl;
    assign wr_status = wr_done & hit_status;
    assign wr_mask   = wr_done & hit_mask;
    assign wr_vector = wr_done & hit_vector;

    // Pin synchroniser
    eil_sync_cell #(
        .RESET_LEVEL (1'b1)
    ) u_pin_sync (
        .clock (clock),
        .reset (reset),
        .din   (irq_pin_n),
        .dout  (pin_sync)
    );

    // Break with clear-enable low protects the latch from software
    assign ack_allowed  = ~break_state | break_clear_enable;
    assign sw_ack_write = wr_ctrl & pwdata[`EIL_BIT_ACK];
    assign sw_ack       = sw_ack_write & ack_allowed;
    assign any_ack      = sw_ack | vector_fetch;

    eil_trigger_latch u_trigger (
        .clock      (clock),
        .reset      (reset),
        .pin_sync   (pin_sync),
        .level_mode (mode_r),
        .ack        (any_ack),
        .latch      (latch),
        .latch_next (latch_nxt),
        .set_event  (set_event)
    );

    // Interrupt status bit follows every latch event
    // Clearing it leaves the latch itself untouched
    assign status_clear = wr_status & pwdata[`EIL_BIT_EVENT];

    eil_sticky_flag u_status (
        .clock     (clock),
        .reset     (reset),
        .raise     (set_event),
        .clear     (status_clear),
        .flag      (int_status),
        .flag_next (int_status_nxt)
    );

    // Sensitivity select
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_r <= 1'b0;
        end else if (wr_ctrl) begin
            mode_r <= pwdata[`EIL_BIT_MODE];
        end
    end

    // Request mask
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            mask_r <= 1'b0;
        end else if (wr_ctrl) begin
            mask_r <= pwdata[`EIL_BIT_MASK];
        end
    end

    // Interrupt enable for the irq output
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            int_mask_r <= 1'b0;
        end else if (wr_mask) begin
            int_mask_r <= pwdata[`EIL_BIT_EVENT];
        end
    end

    // Vector word handed to the CPU a byte at a time
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            vector_r <= VECTOR_DEFAULT;
        end else if (wr_vector) begin
            vector_r <= pwdata[15:0];
        end
    end

    // Read mux; acknowledge bit position always reads zero
    always @* begin
        read_word = 32'h00000000;
        case (paddr)
            ADDR_CTRL: begin
                read_word[`EIL_BIT_MODE] = mode_r;
                read_word[`EIL_BIT_MASK] = mask_r;
                read_word[`EIL_BIT_ACK]  = 1'b0;
                read_word[`EIL_BIT_FLAG] = latch;
            end
            ADDR_STATUS: begin
                read_word[`EIL_BIT_EVENT] = int_status;
            end
            ADDR_MASK: begin
                read_word[`EIL_BIT_EVENT] = int_mask_r;
            end
            ADDR_VECTOR: begin
                read_word[15:0] = vector_r;
            end
            default: begin
                read_word = 32'h00000000;
            end
        endcase
    end

    // One wait state: pready and read data follow the first access edge
    // Unmapped words answer with pslverr and ignore writes
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= access_first;
            pslverr <= access_first & ~addr_ok;
            if (rd_first) begin
                prdata <= read_word;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    assign request_nxt = latch_nxt & ~mask_r;
    assign wake_nxt    = request_nxt & (wait_mode | stop_mode);

    // CPU request and wake-up, registered from the next latch value
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            cpu_request <= 1'b0;
            wakeup      <= 1'b0;
        end else begin
            cpu_request <= request_nxt;
            wakeup      <= wake_nxt;
        end
    end

    // Vector byte, high byte at select zero
    // Select is sampled each cycle; the byte stands one cycle later
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            vector_byte <= 8'h00;
        end else if (vector_byte_sel) begin
            vector_byte <= vector_r[7:0];
        end else begin
            vector_byte <= vector_r[15:8];
        end
    end

    // Synchronised pin level for the branch-on-pin instructions
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            pin_level <= 1'b1;
        end else begin
            pin_level <= pin_sync;
        end
    end

    // Level interrupt while an enabled status bit stands
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= int_status_nxt & int_mask_r;
        end
    end
endmodule // eil_external_interrupt_latch

// *** sim/eil_pin_source.sv ***
// Pin source model
`timescale 1ns/1ps
module eil_pin_source (
    input  wire clock,
    input  wire drive_low,
    output reg  irq_pin_n = 1'b1
);
    always @(posedge clock) irq_pin_n <= ~drive_low;
endmodule // eil_pin_source

// *** sim/eil_checker_properties.sv ***
// Latch port checks
`timescale 1ns/1ps
module eil_checker (
    input wire clock,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire irq_pin_n,
    input wire cpu_request,
    input wire wakeup,
    input wire pin_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_one_wait: assert property ($rose(penable) && psel |=> pready) else $error("late");
    a_rdy_pulse: assert property (pready |=> !pready) else $error("long");
    a_err_rdy: assert property (pslverr |-> pready) else $error("err");
    a_rst_quiet: assert property (disable iff (1'b0)
        reset |-> !cpu_request && !wakeup) else $error("rst");
    a_sync_pin: assert property ($fell(irq_pin_n) |-> pin_level) else $error("sync");
    a_pin_lo: assert property ($fell(irq_pin_n) |-> ##[1:4] !pin_level) else $error("lo");
    a_pin_hi: assert property ($rose(irq_pin_n) |-> ##[1:4] pin_level) else $error("hi");
    a_wake_req: assert property (wakeup |-> cpu_request || $past(cpu_request))
        else $error("wake");
    cover property (wakeup);
    cover property (cpu_request);
    cover property (pslverr);
endmodule // eil_checker
bind eil_external_interrupt_latch eil_checker u_chk (.*);

// *** sim/tb_eil_external_interrupt_latch.sv ***
// Latch bench
`timescale 1ns/1ps
module tb_eil_external_interrupt_latch;
    reg clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, low = 0, es;
    reg vector_fetch = 0, vector_byte_sel = 0, break_state = 0, break_clear_enable = 0;
    reg wait_mode = 0, stop_mode = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd, err_total = 0, samples_checked = 0, cyc = 0;
    reg [15:0] lf = 16'hF1E7;
    wire [31:0] prdata;
    wire [7:0] vector_byte;
    wire pready, pslverr, irq_pin_n, cpu_request, wakeup, pin_level, irq;
    eil_pin_source SRC (.clock, .drive_low(low), .irq_pin_n);
    eil_external_interrupt_latch DUT (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_pin_n(irq_pin_n), .vector_fetch(vector_fetch),
        .vector_byte_sel(vector_byte_sel), .break_state(break_state),
        .break_clear_enable(break_clear_enable), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .cpu_request(cpu_request), .wakeup(wakeup),
        .vector_byte(vector_byte), .pin_level(pin_level), .irq(irq));
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin err_total = err_total + 1; end_of_test; end
    end
    task end_of_test;
        if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cmp(input [63:0] nm, input [31:0] e, g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("wrong value %0s exp %h seen %h", nm, e, g);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clock) penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        {rd, es} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        // Idle gap so registered outputs settle
        repeat (3) @(posedge clock);
    endtask
    task st(input [31:0] d); apb(1, 12'h000, d); endtask
    task ck(input [31:0] e); apb(0, 12'h000, 0); cmp("status", e, rd); endtask
    task pin(input v); low <= v; repeat (8) @(posedge clock); endtask
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    initial begin
        repeat (12) @(posedge clock);
        reset <= 0;
        @(posedge clock) ck(0);
        st(7); ck(3);
        st(0); pin(1); ck(8);
        cmp("lvl", 0, pin_level);
        cmp("req", 1, cpu_request);
        st(4); ck(0);
        pin(0); pin(1); ck(8);
        vector_fetch <= 1;
        @(posedge clock) vector_fetch <= 0;
        pin(1); cmp("req", 0, cpu_request);
        st(1); st(5); ck(9); pin(0); ck(1);
        st(2); wait_mode <= 1; pin(1); ck(10);
        st(0); cmp("wake", 1, wakeup);
        {wait_mode, stop_mode} <= 2'b01; st(4); cmp("wake", 0, wakeup);
        pin(0); pin(1); cmp("wake", 1, wakeup);
        {stop_mode, break_state} <= 2'b01; st(4); ck(8);
        break_clear_enable <= 1; st(4); ck(0);
        apb(0, 12'h004, 0); cmp("stat", 1, rd);
        cmp("irq", 0, irq); apb(1, 12'h008, 1); cmp("irq", 1, irq);
        apb(1, 12'h004, 1); cmp("irq", 0, irq); apb(0, 12'h010, 0); cmp("err", 1, es);
        repeat (6) begin
            lf = lfsr(lf);
            vector_byte_sel <= 1'b0;
            apb(1, 12'h00C, {16'h0000, lf}); cmp("vhi", lf[15:8], vector_byte);
            apb(0, 12'h00C, 0); cmp("vec", {16'h0000, lf}, rd);
            vector_byte_sel <= 1'b1;
            @(posedge clock) @(posedge clock) cmp("vlo", lf[7:0], vector_byte);
        end
        st(3); pin(1); pin(0); ck(11);
        reset <= 1'b1;
        @(posedge clock) reset <= 1'b0;
        @(posedge clock) ck(0);
        cmp("req", 0, cpu_request);
        end_of_test;
    end
endmodule // tb_eil_external_interrupt_latch
